// file: ext_bus_ack_termination.sv
`timescale 1ns/10ps
`include "ack_term_consts.svh"
// Functional notes
// - with acknowledge enabled the cycle ends on the acknowledge input.
// - a cycle not acknowledged within 1024 clocks raises a bus error.
// - edge mode and level mode with an ignore interval are selectable.
// - acknowledge is honoured only on asynchronous cycles.
// - edge mode completes the cycle after a rising acknowledge edge.
// - edge mode is only available on chip select 5.
// - level mode ignores the input for 2 to 5 programmed clocks.
// - a high sample after the interval continues with the wait states.
// - a low sample after the interval stalls until high, within timeout.
// - a low at any point after the ignore interval of a level cycle pauses until high again.
// - level mode works on every chip select except chip select 4.
module ext_bus_ack_termination
  import ack_term_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `ACK_TIMEOUT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cycle_start,
  input wire logic [2:0] cycle_cs,
  input wire logic cs_sync_mode,
  input wire logic ack_wait_enable,
  input wire logic ack_edge_select,
  input wire logic [2:0] ack_ignore_time,
  input wire logic [5:0] wait_state_count,
  input wire logic ext_transfer_ack,
  output logic cycle_busy,
  output logic cycle_done,
  output logic bus_error,
  output logic ack_stalled
);

  // refuse a limit that the timeout counter cannot hold
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << `ACK_TIMEOUT_W)) begin
    $error("TIMEOUT_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // reset release and acknowledge synchronisation

  logic rst_meta_q;
  logic rst_n_q;
  logic ack_s;
  logic ack_prev_q;

  // reset releases through two flops, asserts at once
  // so every flop leaves reset on the same clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ack_sync u_ack_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n_q),
    .async_level(ext_transfer_ack),
    .sync_level(ack_s)
  );

  // previous synchronised level for the rising-edge detector
  // reset high like the idle pin, so reset never fakes a rise
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) ack_prev_q <= 1'b1;
    else ack_prev_q <= ack_s;
  end

  wire ack_rise = ack_s & ~ack_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // per-cycle mode capture

  // clamp the ignore field to the supported window
  // out-of-range codes degrade to the nearest legal time, not refused
  function automatic logic [2:0] clamp_ignore(input logic [2:0] v);
    if (v < `ACK_IGNORE_MIN) return `ACK_IGNORE_MIN;
    else if (v > `ACK_IGNORE_MAX) return `ACK_IGNORE_MAX;
    else return v;
  endfunction

  logic edge_mode_q;
  logic ack_used_q;
  logic [5:0] wait_q;
  logic [2:0] ignore_q;
  localparam int TMO_W = `ACK_TIMEOUT_W;
  logic [TMO_W-1:0] tmo_q;
  logic [2:0] ign_cnt_q;
  logic armed_q;
  cycle_state_e state_q;

  // only idle takes a request; the done clock refuses one
  wire start_ok = cycle_start && (state_q == ST_IDLE);
  // acknowledge only counts on asynchronous cycles
  wire use_edge = ack_edge_select && !cs_sync_mode &&
                  (cycle_cs == `ACK_EDGE_CS);
  wire use_level = !ack_edge_select && ack_wait_enable && !cs_sync_mode &&
                   (cycle_cs != `ACK_SHARED_CS);

  // settings latched at cycle start so mid-cycle writes have no effect
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      edge_mode_q <= 1'b0;
      ack_used_q <= 1'b0;
      wait_q <= 6'h00;
      ignore_q <= `ACK_IGNORE_MIN;
    end else if (start_ok) begin
      edge_mode_q <= use_edge;
      ack_used_q <= use_edge || use_level;
      wait_q <= wait_state_count;
      ignore_q <= clamp_ignore(ack_ignore_time);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timeout monitor

  wire tmo_hit = ack_used_q && (tmo_q == TMO_W'(TIMEOUT_CYCLES - 1));

  // restarted on each cycle start, counts while busy
  // on acknowledge cycles the count parks at its limit so the error waits for the sequencer
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) tmo_q <= {TMO_W{1'b0}};
    else if (start_ok) tmo_q <= {TMO_W{1'b0}};
    else if (cycle_busy && !tmo_hit) tmo_q <= tmo_q + TMO_W'(1);
  end

  // edge arming: needs a low seen inside this cycle before a rise
  // counts, so a stale high from the last cycle never ends this one
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) armed_q <= 1'b0;
    else if (start_ok) armed_q <= !ack_s; // a low on the start clock counts
    else if (!ack_s) armed_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  logic [5:0] ws_q;

  // a cycle runs in every state but idle and the two end states
  function automatic logic state_active(input cycle_state_e s);
    case (s)
      ST_IGNORE, ST_WAIT, ST_STALL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // the end states, each held for exactly one clock
  function automatic logic state_final(input cycle_state_e s);
    case (s)
      ST_DONE, ST_ERROR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      ign_cnt_q <= 3'h0;
      ws_q <= 6'h00;
    end else begin
      case (state_q)
        // idle until a request is taken
        ST_IDLE: begin
          if (start_ok) begin
            ign_cnt_q <= 3'h1;
            ws_q <= 6'h00;
            state_q <= ST_IGNORE;
          end
        end
        ST_IGNORE: begin
          // level mode holds off sampling for the programmed time
          // limitation: a low that ends inside this time is never seen
          if (!ack_used_q || edge_mode_q || ign_cnt_q >= ignore_q)
            state_q <= ST_WAIT;
          else ign_cnt_q <= ign_cnt_q + 3'h1;
        end
        // edge mode waits for an armed rise; level mode stalls on a low
        ST_WAIT: begin
          if (tmo_hit) state_q <= ST_ERROR;
          else if (ack_used_q && edge_mode_q) begin
            if (ack_rise && armed_q) state_q <= ST_DONE;
          end else if (ack_used_q && !ack_s) begin
            state_q <= ST_STALL;
          end else if (ws_q >= wait_q) begin
            state_q <= ST_DONE;
          end else ws_q <= ws_q + 6'h01;
        end
        // held while the far side keeps the line low
        ST_STALL: begin
          if (tmo_hit) state_q <= ST_ERROR;
          else if (ack_s) state_q <= ST_WAIT;
        end
        // end states last one clock, then back to idle
        ST_DONE: state_q <= ST_IDLE;
        ST_ERROR: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status decode

  // status outputs follow the sequencer state; no extra flop, so
  // done lines up with the clock in which the sequencer left wait
  assign cycle_busy = state_active(state_q);
  assign cycle_done = state_final(state_q);
  assign bus_error = (state_q == ST_ERROR);
  assign ack_stalled = (state_q == ST_STALL);
endmodule

// file: ack_term_consts.svh
`ifndef ACK_TERM_CONSTS_SVH
`define ACK_TERM_CONSTS_SVH

// timeout figure in bus clock cycles
`define ACK_TIMEOUT_CYCLES 1024
// counter width holding the timeout count
`define ACK_TIMEOUT_W 11
// chip select wired to rising-edge acknowledge
`define ACK_EDGE_CS 3'h5
// chip select whose pin is shared with the acknowledge input
`define ACK_SHARED_CS 3'h4
// insensitivity interval limits in clocks
`define ACK_IGNORE_MIN 3'h2
`define ACK_IGNORE_MAX 3'h5
// wait-state value that parks edge mode on the acknowledge
`define ACK_EDGE_WAIT 6'h3f

`endif

// file: ack_term_pkg.sv
package ack_term_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_IGNORE = 3'b001,
    ST_WAIT = 3'b010,
    ST_STALL = 3'b011,
    ST_DONE = 3'b100,
    ST_ERROR = 3'b101
  } cycle_state_e;
endpackage

// file: ack_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser; the first stage feeds only the second
module ack_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic async_level,
  output logic sync_level
);
  logic meta_q;
  logic sync_q;

  // pin idles high, so reset to high to avoid a false low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_level;
      sync_q <= meta_q;
    end
  end

  // second stage drives the port straight from its flop
  assign sync_level = sync_q;
endmodule

// file: ack_term_monitor.sv
`timescale 1ns/10ps
module ack_term_monitor #(parameter int TIMEOUT_CYCLES = 1024) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cycle_start,
  input wire logic [2:0] cycle_cs,
  input wire logic cs_sync_mode,
  input wire logic ack_wait_enable,
  input wire logic ack_edge_select,
  input wire logic [2:0] ack_ignore_time,
  input wire logic [5:0] wait_state_count,
  input wire logic ext_transfer_ack,
  input wire logic cycle_busy,
  input wire logic cycle_done,
  input wire logic bus_error,
  input wire logic ack_stalled
);
  int cnt_q;
  logic am;
  // acknowledge counts only on async cycles of a legal select
  assign am = !cs_sync_mode && (ack_edge_select ? cycle_cs == 3'h5 :
    ack_wait_enable && cycle_cs != 3'h4);
  // busy length so far; inputs change at done, hence $past below
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= 0;
    else cnt_q <= cycle_busy ? cnt_q + 1 : 0;
  end
  //////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_take; cycle_start && !cycle_busy && !cycle_done; endsequence
  sequence s_rise; !ext_transfer_ack ##1 ext_transfer_ack; endsequence
  AST_TAKE:
    assert property (s_take |=> cycle_busy) else $error("no busy");
  AST_ERR_DONE:
    assert property (bus_error |-> cycle_done) else $error("lone err");
  AST_ERR_ACK:
    assert property (bus_error |-> $past(am)) else $error("err off ack");
  AST_ERR_TIME:
    assert property (bus_error |-> cnt_q >= TIMEOUT_CYCLES - 3 &&
      cnt_q <= TIMEOUT_CYCLES) else $error("timeout len");
  AST_PLAIN:
    assert property (cycle_done && !$past(am) |->
      cnt_q == $past(wait_state_count) + 2) else $error("plain len");
  AST_STALL:
    assert property (ack_stalled |-> cycle_busy && am) else $error("stall");
  AST_RELEASE:
    assert property (s_rise ##0 ack_stalled |-> ##[1:5] !ack_stalled)
      else $error("stall held");
  // pin rose three clocks before done: two sync flops plus the state flop
  AST_EDGE:
    assert property (cycle_done && !bus_error && $past(am && ack_edge_select)
      |-> $past(ext_transfer_ack, 3) && !$past(ext_transfer_ack, 4))
      else $error("edge done");
  AST_DONE_ONE:
    assert property (cycle_done |=> !cycle_done) else $error("done held");
endmodule

// file: ack_peer.sv
`timescale 1ns/10ps
// slow peripheral: holds ready low for low_len cycles when armed
module ack_peer (
  input wire logic ref_clk,
  input wire logic arm,
  input wire logic [7:0] low_len,
  output logic ext_transfer_ack = 1'b1
);
  int n = 0;
  // idle high, so the device is ready unless told to stall
  always @(negedge ref_clk) begin
    if (arm) n = low_len;
    ext_transfer_ack <= n == 0;
    if (n > 0) n--;
  end
endmodule

// file: ext_bus_ack_termination_tb.sv
`timescale 1ns/10ps
module ext_bus_ack_termination_tb;
  logic ref_clk = 0, arst_n = 0, cycle_start = 0, arm = 0, st = 0;
  logic cs_sync_mode = 0, ack_wait_enable = 0, ack_edge_select = 0;
  logic [2:0] cycle_cs = 0, ack_ignore_time = 0, pc[4], pm[4];
  logic [5:0] wait_state_count = 0;
  logic [7:0] low_len = 0, rnd = 8'h36;
  logic ext_transfer_ack, cycle_busy, cycle_done, bus_error, ack_stalled;
  logic [9:0] notes[$], ex;
  int err_count = 0, check_count = 0, len = 0;
  ext_bus_ack_termination #(.TIMEOUT_CYCLES(32)) uut (.*);
  ack_peer peer (.*);
  initial forever #4 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nx(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(logic [9:0] seen, logic [9:0] want);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] err_stall_len exp %h seen %h", want, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // program the select, arm the peer, request, wait a bounded time
  task automatic run(logic [2:0] cs, m, ig, logic [5:0] ws,
      logic [7:0] lo, logic [9:0] e);
    int i;
    {cs_sync_mode, ack_wait_enable, ack_edge_select, cycle_cs,
      ack_ignore_time, wait_state_count, low_len} <= {m, cs, ig, ws, lo};
    {arm, cycle_start} <= 2'b11;
    notes.push_back(e);
    @(negedge ref_clk);
    {arm, cycle_start} <= 2'b00;
    for (i = 0; i < 300 && cycle_done !== 1'b1; i++) @(negedge ref_clk);
    if (i == 300) err_count++;
    @(negedge ref_clk); // the done clock refuses a new request
    $display("cycle on select %0d over", cs);
  endtask
  // each finished cycle is matched with the oldest note
  always @(negedge ref_clk) begin
    if (cycle_done === 1'b1) begin
      ex = notes.pop_front();
      chk({bus_error, st, ex[7:0] != 8'h0 ? 8'(len) : 8'h0}, ex);
      st = 0;
      len = 0;
    end else if (cycle_busy === 1'b1) len++;
    if (ack_stalled === 1'b1 && ack_edge_select === 1'b0) st = 1;
  end
  initial begin
    pc = '{3'h1, 3'h2, 3'h4, 3'h6};
    pm = '{3'h6, 3'h1, 3'h2, 3'h0};
    repeat (3) @(negedge ref_clk);
    arst_n <= 1;
    repeat (3) @(negedge ref_clk);
    // ack ignored: sync, edge off select 5, level on select 4, disabled
    for (int k = 0; k < 4; k++) begin
      rnd = nx(rnd);
      run(pc[k], pm[k], 3'h2, rnd[5:0], nx(rnd), rnd[5:0] + 10'h2);
    end
    // level mode, every ignore time, peer ready: ignore + wait + 1 clocks
    for (int k = 2; k < 6; k++) begin
      run(3'(k - 2), 3'h2, 3'(k), 6'h2, 8'h0, 10'(k + 3));
    end
    run(3'h0, 3'h2, 3'h2, 6'h2, 8'h8, 10'h100);
    run(3'h7, 3'h2, 3'h5, 6'h2, 8'hc8, 10'h300);
    run(3'h5, 3'h1, 3'h2, 6'h3f, 8'h4, 10'h0);
    run(3'h5, 3'h1, 3'h2, 6'h3f, 8'h0, 10'h200);
    run(3'h5, 3'h1, 3'h2, 6'h3f, 8'hc8, 10'h200);
    give_verdict;
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #50us;
    err_count++;
    give_verdict;
  end
endmodule
bind ext_bus_ack_termination ack_term_monitor
  #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon (.*);
